// ===== bench/mdu_chk.sv
// Purpose: Port-level timing and result checks on the multiply/divide unit
// Assumes: Sees only the top-level ports
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps
module mdu_chk
  import mdu_pkg::*;
(
  input wire logic     clk_sys,
  input wire logic     reset_n,
  input wire logic     issue_valid,
  input wire mdu_req_t issue_req,
  input wire logic     stall_out,
  input wire mdu_wb_t  wb_out,
  input wire logic     [31:0] upper_half,
  input wire logic     [31:0] bottom_half
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic       acc, shrt, is_mul, is_div, sd;
  logic [5:0] div_n, cnt_r, cnt_nxt;
  function automatic logic fits(logic s, logic [31:0] a, int w);
    logic signed [31:0] t;
    logic [31:0]        u;
    t = a << (32 - w);
    u = t >>> (32 - w);
    return s ? (u == a) : ((a >> w) == 0);
  endfunction
  function automatic logic [63:0] sprod(logic [31:0] a, logic [31:0] b);
    return 64'(longint'($signed(a)) * longint'($signed(b)));
  endfunction
  assign acc    = issue_valid && !stall_out;
  assign is_mul = issue_req.op inside {[MDU_OP_MULT:MDU_OP_MUL]};
  assign is_div = issue_req.op inside {MDU_OP_DIV, MDU_OP_DIV_U};
  assign sd     = issue_req.op == MDU_OP_DIV;
  assign shrt   = fits(issue_req.op inside {MDU_OP_MULT, MDU_OP_MACC, MDU_OP_MDED, MDU_OP_MUL},
                       issue_req.operand_b, 16);
  assign div_n  = fits(sd, issue_req.operand_a, 8)  ? MDU_DIV_ITER - MDU_SKIP_8  :
                  fits(sd, issue_req.operand_a, 16) ? MDU_DIV_ITER - MDU_SKIP_16 :
                  fits(sd, issue_req.operand_a, 24) ? MDU_DIV_ITER - MDU_SKIP_24 : MDU_DIV_ITER;
  // Cycles of divide still to run
  always_comb begin
    cnt_nxt = (cnt_r != 6'h00) ? cnt_r - 6'h01 : 6'h00;
    if (acc && is_div)
      cnt_nxt = div_n;
    if (!reset_n)
      cnt_nxt = 6'h00;
  end
  always_ff @(posedge clk_sys) begin
    cnt_r <= cnt_nxt;
  end
  sequence s_div9;
    stall_out [*8] ##1 stall_out;
  endsequence
  sequence s_lock;
    stall_out ##1 !stall_out;
  endsequence
  property p_short_rate; acc && is_mul && shrt |=> !stall_out; endproperty
  property p_full_lock; acc && is_mul && !shrt |=> s_lock; endproperty
  property p_mul16;
    acc && issue_req.op == MDU_OP_MUL && shrt |-> ##2 wb_out.valid && wb_out.dest == $past(issue_req.dest, 2);
  endproperty
  property p_mul32;
    acc && issue_req.op == MDU_OP_MUL && !shrt |-> ##3 wb_out.valid && wb_out.dest == $past(issue_req.dest, 3);
  endproperty
  property p_div8; acc && is_div && div_n == 6'h09 |=> s_div9 ##1 !stall_out; endproperty
  property p_div_hold; cnt_r != 6'h00 |-> stall_out; endproperty
  property p_div_end; cnt_r == 6'h01 |=> !stall_out; endproperty
  property p_move;
    acc && issue_req.op inside {MDU_OP_MFUP, MDU_OP_MFBOT} |=> wb_out.valid && wb_out.data ==
      ($past(issue_req.op) == MDU_OP_MFUP ? $past(upper_half) : $past(bottom_half));
  endproperty
  property p_mult16;
    acc && issue_req.op == MDU_OP_MULT && shrt |=> {upper_half, bottom_half} ==
      sprod($past(issue_req.operand_a), $past(issue_req.operand_b));
  endproperty
  a_short_rate: assert property (p_short_rate) else $error("short multiply stalled");
  a_full_lock: assert property (p_full_lock) else $error("full multiply interlock wrong");
  a_mul16: assert property (p_mul16) else $error("short register multiply late");
  a_mul32: assert property (p_mul32) else $error("full register multiply late");
  a_div8: assert property (p_div8) else $error("narrow divide length wrong");
  a_div_hold: assert property (p_div_hold) else $error("stall dropped during divide");
  a_div_end: assert property (p_div_end) else $error("divide ran long");
  a_move: assert property (p_move) else $error("move copied wrong half");
  a_mult16: assert property (p_mult16) else $error("short pair product wrong");
endmodule

// ===== bench/mdu_core_tb.sv
// Purpose: Self-checking bench for the multiply/divide unit
// Assumes: Issue through the pipeline stand-in
// Notes:   Random operations with fixed seed plus corner cases
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module mdu_core_tb
  import mdu_pkg::*;
;
  logic        clk_sys, reset_n, issue_valid, stall_out;
  mdu_req_t    issue_req;
  mdu_wb_t     wb_out;
  logic [31:0] upper_half, bottom_half, a, b, exp_wb;
  logic [31:0] wb_dat = '0;
  logic [63:0] pair = '0;
  int          n_errors = 0, compares = 0, seed = 32'hf797, k;
  mdu_op_t     op;
  mdu_core i_mdu_core (.clk_sys(clk_sys), .reset_n(reset_n), .issue_valid(issue_valid),
    .issue_req(issue_req), .stall_out(stall_out), .wb_out(wb_out),
    .upper_half(upper_half), .bottom_half(bottom_half));
  mdu_issue_model i_mdu_issue_model (.clk_sys(clk_sys), .stall_out(stall_out),
    .issue_valid(issue_valid), .issue_req(issue_req));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (wb_out.valid === 1'b1) wb_dat <= wb_out.data;
  function automatic logic [63:0] mul64(mdu_op_t o, logic [31:0] x, logic [31:0] y);
    if (o inside {MDU_OP_MULT, MDU_OP_MACC, MDU_OP_MDED, MDU_OP_MUL})
      return 64'(longint'($signed(x)) * longint'($signed(y)));
    return {32'h0, x} * {32'h0, y};
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 60 && stall_out !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 60) begin
      n_errors++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic send(input mdu_op_t o, input logic [31:0] x, input logic [31:0] y);
    i_mdu_issue_model.issue('{o, 5'h05, x, y});
    case (o)
      MDU_OP_MULT, MDU_OP_MULT_U: pair = mul64(o, x, y);
      MDU_OP_MACC, MDU_OP_MACC_U: pair = pair + mul64(o, x, y);
      MDU_OP_MDED, MDU_OP_MDED_U: pair = pair - mul64(o, x, y);
      MDU_OP_DIV: if (y != 0) pair = {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
      MDU_OP_DIV_U: if (y != 0) pair = {x % y, x / y};
      MDU_OP_MUL: exp_wb = 32'(mul64(o, x, y));
      MDU_OP_MFUP: exp_wb = pair[63:32];
      MDU_OP_MFBOT: exp_wb = pair[31:0];
      default: ;
    endcase
  endtask
  task automatic finish_ops();
    i_mdu_issue_model.idle();
    settle();
    `CHK({upper_half, bottom_half}, pair)
    `CHK(wb_dat, exp_wb)
  endtask
  initial begin
    reset_n = 1'b0;
    exp_wb  = '0;
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    `CHK({upper_half, bottom_half, stall_out, wb_out.valid}, {MDU_UPPER_RST, MDU_LOWER_RST, 2'b00})
    a = $random(seed);
    send(MDU_OP_MULT, a, 32'h0000_1234);
    send(MDU_OP_MACC, a, 32'hFFFF_8001);
    send(MDU_OP_MDED, a, 32'h0000_7FFF);
    finish_ops();
    send(MDU_OP_MACC_U, a, 32'h8001_0000);
    send(MDU_OP_MACC_U, a, 32'hFFFF_FFFF);
    send(MDU_OP_MUL, a, 32'h1234_5678);
    finish_ops();
    send(MDU_OP_DIV, 32'h8765_4321, 32'h0000_0013);
    send(MDU_OP_MFBOT, a, a);
    finish_ops();
    send(MDU_OP_DIV_U, 32'h0000_00C3, 32'h0000_0000);
    i_mdu_issue_model.idle();
    repeat (int'(MDU_DIV_ITER - MDU_SKIP_8) - 1) @(posedge clk_sys);
    #1;
    `CHK(stall_out, 1'b1)
    @(posedge clk_sys);
    #1;
    `CHK(stall_out, 1'b0)
    send(MDU_OP_MULT, a, 32'h0000_0000);
    finish_ops();
    for (k = 0; k < 300; k++) begin
      op = mdu_op_t'(4'(1 + ($unsigned($random(seed)) % 11)));
      a = $random(seed);
      a = $signed(a) >>> (8 * (k % 4));
      b = $random(seed);
      if (k[0])
        b = {{16{b[15]}}, b[15:0]};
      if (b == 0)
        b = 32'h0000_0007;
      send(op, a, b);
      finish_ops();
    end
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    pair = '0;
    `CHK({upper_half, bottom_half}, {MDU_UPPER_RST, MDU_LOWER_RST})
    send(MDU_OP_MULT_U, 32'hFFFF_FFFF, 32'h0000_FFFF);
    finish_ops();
    `CHK(i_mdu_issue_model.hung, 1'b0)
    tally_and_finish();
  end
endmodule
bind mdu_core mdu_chk i_mdu_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .issue_valid(issue_valid), .issue_req(issue_req), .stall_out(stall_out),
  .wb_out(wb_out), .upper_half(upper_half), .bottom_half(bottom_half));

// ===== bench/mdu_issue_model.sv
// Purpose: Integer pipeline stand-in issuing operations to the unit
// Assumes: Holds an issue while the unit stalls
// Notes:   Request lines are scrambled while idle
`timescale 1ns/10ps
module mdu_issue_model
  import mdu_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic stall_out,
  output      logic issue_valid,
  output      mdu_req_t issue_req
);
  logic hung = 1'b0;
  initial begin
    issue_valid = 1'b0;
    issue_req   = '0;
  end
  task automatic issue(input mdu_req_t r);
    logic s;
    int   i;
    issue_valid = 1'b1;
    issue_req   = r;
    for (i = 0; i < 80; i++) begin
      @(negedge clk_sys) s = stall_out;
      @(posedge clk_sys);
      if (!s)
        break;
    end
    if (i == 80)
      hung = 1'b1;
    #1;
  endtask
  task automatic idle();
    issue_valid = 1'b0;
    issue_req   = mdu_req_t'(~issue_req);
  endtask
endmodule

// ===== hdl/mdu_booth_array.sv
// Purpose: One pass through the 32x16 radix-4 booth-recoded array
// Assumes: Combinational; caller selects the 16-bit slice of operand_b
// Notes:   Produces a signed 50-bit partial product
`timescale 1ns/10ps
module mdu_booth_array
  import mdu_pkg::*;
(
  input  wire logic [32:0] mcand,
  input  wire logic [16:0] mplier,
  output      logic [49:0] prod
);

  logic [49:0] acc;
  logic [49:0] mc_ext;
  logic [2:0]  grp;

  always_comb begin
    mc_ext = {{17{mcand[32]}}, mcand};
    acc    = '0;
    grp    = '0;
    for (int i = 0; i < 9; i++) begin
      grp = {(2 * i + 1 < 17) ? mplier[2 * i + 1] : mplier[16],
             (2 * i < 17) ? mplier[2 * i] : mplier[16],
             (i == 0) ? 1'b0 : mplier[2 * i - 1]};
      unique case (grp)
        3'h1, 3'h2: acc = acc + (mc_ext << (2 * i));
        3'h3:       acc = acc + (mc_ext << (2 * i + 1));
        3'h4:       acc = acc - (mc_ext << (2 * i + 1));
        3'h5, 3'h6: acc = acc - (mc_ext << (2 * i));
        default:    acc = acc;
      endcase
    end
    prod = acc;
  end

endmodule

// ===== hdl/mdu_core.sv
// Purpose: Integer multiply/divide unit beside the integer pipeline
// Assumes: Issue is one-cycle valid with a decoded op; stall_out holds issue
// Notes:   Results go to the upper/bottom pair or a general register port
`timescale 1ns/10ps
module mdu_core
  import mdu_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     reset_n,
  input  wire logic     issue_valid,
  input  wire mdu_req_t issue_req,
  output      logic     stall_out,
  output      mdu_wb_t  wb_out,
  output      logic     [31:0] upper_half,
  output      logic     [31:0] bottom_half
);

  typedef enum logic [1:0] {MDU_IDLE, MDU_MUL2, MDU_DIV} mdu_state_t;

  mdu_state_t  state_r, state_nxt;
  mdu_req_t    req_r, req_nxt;
  logic [31:0] upper_r, upper_nxt;
  logic [31:0] lower_r, lower_nxt;
  logic [48:0] part_r, part_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [31:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [31:0] dvs_r, dvs_nxt;
  logic        dneg_q_r, dneg_q_nxt;
  logic        dneg_r_r, dneg_r_nxt;
  logic        stall_r, stall_nxt;
  mdu_wb_t     wb_r, wb_nxt;
  mdu_wb_t     wbq_r, wbq_nxt;

  logic        sgn;
  logic        short_b;
  logic [32:0] mcand;
  logic [16:0] mplier;
  logic [49:0] pp;
  logic [63:0] prod;
  logic [63:0] pair;
  logic [31:0] a_mag;
  logic [31:0] b_mag;
  logic [5:0]  iters;
  logic [32:0] trial;
  logic [31:0] rem_sh;
  logic        take;
  mdu_op_t     op;

  function automatic logic is_mul(input mdu_op_t o);
    return o inside {MDU_OP_MULT, MDU_OP_MULT_U, MDU_OP_MACC, MDU_OP_MACC_U,
                     MDU_OP_MDED, MDU_OP_MDED_U, MDU_OP_MUL};
  endfunction

  function automatic logic is_signed(input mdu_op_t o);
    return o inside {MDU_OP_MULT, MDU_OP_MACC, MDU_OP_MDED, MDU_OP_MUL, MDU_OP_DIV};
  endfunction

  // One array pass: first pass uses low slice, second the upper slice
  mdu_booth_array u_array (
    .mcand  (mcand),
    .mplier (mplier),
    .prod   (pp)
  );

  always_comb begin
    op    = issue_req.op;
    sgn   = is_signed(state_r == MDU_IDLE ? op : req_r.op);
    // Width detection from operand_b value and the op's signedness
    short_b = sgn ? (issue_req.operand_b[31:15] == {17{issue_req.operand_b[15]}})
                  : (issue_req.operand_b[31:16] == 16'h0000);
    if (state_r == MDU_MUL2) begin
      mcand  = {sgn & req_r.operand_a[31], req_r.operand_a};
      mplier = {sgn & req_r.operand_b[31], req_r.operand_b[31:16]};
    end else begin
      mcand  = {sgn & issue_req.operand_a[31], issue_req.operand_a};
      mplier = short_b ? {sgn & issue_req.operand_b[15], issue_req.operand_b[15:0]}
                       : {1'b0, issue_req.operand_b[15:0]};
    end
    a_mag = (is_signed(op) && issue_req.operand_a[31]) ? 32'(-issue_req.operand_a)
                                                        : issue_req.operand_a;
    b_mag = (is_signed(op) && issue_req.operand_b[31]) ? 32'(-issue_req.operand_b)
                                                        : issue_req.operand_b;
    // Early-in from dividend sign extension
    if (is_signed(op) ? (issue_req.operand_a[31:7] == {25{issue_req.operand_a[7]}})
                      : (issue_req.operand_a[31:8] == 24'h000000))
      iters = 6'(MDU_DIV_ITER - MDU_SKIP_8);
    else if (is_signed(op) ? (issue_req.operand_a[31:15] == {17{issue_req.operand_a[15]}})
                           : (issue_req.operand_a[31:16] == 16'h0000))
      iters = 6'(MDU_DIV_ITER - MDU_SKIP_16);
    else if (is_signed(op) ? (issue_req.operand_a[31:23] == {9{issue_req.operand_a[23]}})
                           : (issue_req.operand_a[31:24] == 8'h00))
      iters = 6'(MDU_DIV_ITER - MDU_SKIP_24);
    else
      iters = MDU_DIV_ITER;
    rem_sh = {rem_r[30:0], quo_r[31]};
    // Full 33-bit partial remainder keeps divisors above 2^31 exact
    trial  = {rem_r, quo_r[31]} - {1'b0, dvs_r};
    take   = ~trial[32];
  end

  always_comb begin
    state_nxt  = state_r;
    req_nxt    = req_r;
    upper_nxt  = upper_r;
    lower_nxt  = lower_r;
    part_nxt   = part_r;
    cnt_nxt    = cnt_r;
    rem_nxt    = rem_r;
    quo_nxt    = quo_r;
    dvs_nxt    = dvs_r;
    dneg_q_nxt = dneg_q_r;
    dneg_r_nxt = dneg_r_r;
    stall_nxt  = 1'b0;
    wb_nxt     = wbq_r;
    wbq_nxt    = '{valid: 1'b0, dest: 5'h00, data: 32'h0000_0000};
    pair       = {upper_r, lower_r};
    prod       = 64'({{14{pp[49]}}, pp});
    unique case (state_r)
      MDU_IDLE: begin
        if (issue_valid && is_mul(op)) begin
          if (short_b) begin
            // Single pass; pair result ready next clock, MUL writeback on wb_out two clocks later
            unique case (op)
              MDU_OP_MACC, MDU_OP_MACC_U: {upper_nxt, lower_nxt} = pair + prod;
              MDU_OP_MDED, MDU_OP_MDED_U: {upper_nxt, lower_nxt} = pair - prod;
              MDU_OP_MUL: wbq_nxt = '{valid: 1'b1, dest: issue_req.dest,
                                      data: prod[31:0]};
              default: {upper_nxt, lower_nxt} = prod;
            endcase
          end else begin
            // Second pass follows; next issue is held one clock
            req_nxt   = issue_req;
            part_nxt  = pp[48:0];
            state_nxt = MDU_MUL2;
            stall_nxt = 1'b1;
          end
        end else if (issue_valid && (op == MDU_OP_DIV || op == MDU_OP_DIV_U)) begin
          // Divide by zero runs the same count, no fault
          req_nxt    = issue_req;
          dvs_nxt    = b_mag;
          quo_nxt    = a_mag << (6'(MDU_DIV_ITER) - iters);
          rem_nxt    = 32'h0000_0000;
          cnt_nxt    = iters;
          dneg_q_nxt = is_signed(op) & (issue_req.operand_a[31] ^ issue_req.operand_b[31]);
          dneg_r_nxt = is_signed(op) & issue_req.operand_a[31];
          state_nxt  = MDU_DIV;
          stall_nxt  = 1'b1;
        end else if (issue_valid && op == MDU_OP_MFUP) begin
          wb_nxt = '{valid: 1'b1, dest: issue_req.dest, data: upper_r};
        end else if (issue_valid && op == MDU_OP_MFBOT) begin
          wb_nxt = '{valid: 1'b1, dest: issue_req.dest, data: lower_r};
        end
      end
      MDU_MUL2: begin
        // Combines passes regardless of pipeline stall
        prod = 64'({{14{pp[49]}}, pp} << 16) + 64'({{15{part_r[48]}}, part_r});
        unique case (req_r.op)
          MDU_OP_MACC, MDU_OP_MACC_U: {upper_nxt, lower_nxt} = pair + prod;
          MDU_OP_MDED, MDU_OP_MDED_U: {upper_nxt, lower_nxt} = pair - prod;
          MDU_OP_MUL: wbq_nxt = '{valid: 1'b1, dest: req_r.dest,
                                  data: prod[31:0]};
          default: {upper_nxt, lower_nxt} = prod;
        endcase
        state_nxt = MDU_IDLE;
      end
      MDU_DIV: begin
        // One quotient bit per clock
        rem_nxt   = take ? trial[31:0] : rem_sh;
        quo_nxt   = {quo_r[30:0], take};
        cnt_nxt   = 6'(cnt_r - 6'h01);
        stall_nxt = 1'b1;
        if (cnt_r == 6'h01) begin
          // Final step; result pair loads, stall drops
          lower_nxt = dneg_q_r ? 32'(-{quo_r[30:0], take}) : {quo_r[30:0], take};
          upper_nxt = dneg_r_r ? 32'(-(take ? trial[31:0] : rem_sh))
                               : (take ? trial[31:0] : rem_sh);
          stall_nxt = 1'b0;
          state_nxt = MDU_IDLE;
        end
      end
      default: state_nxt = MDU_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r  <= MDU_IDLE;
      req_r    <= '0;
      upper_r  <= MDU_UPPER_RST;
      lower_r  <= MDU_LOWER_RST;
      part_r   <= '0;
      cnt_r    <= '0;
      rem_r    <= '0;
      quo_r    <= '0;
      dvs_r    <= '0;
      dneg_q_r <= 1'b0;
      dneg_r_r <= 1'b0;
      stall_r  <= 1'b0;
      wb_r     <= '0;
      wbq_r    <= '0;
    end else begin
      state_r  <= state_nxt;
      req_r    <= req_nxt;
      upper_r  <= upper_nxt;
      lower_r  <= lower_nxt;
      part_r   <= part_nxt;
      cnt_r    <= cnt_nxt;
      rem_r    <= rem_nxt;
      quo_r    <= quo_nxt;
      dvs_r    <= dvs_nxt;
      dneg_q_r <= dneg_q_nxt;
      dneg_r_r <= dneg_r_nxt;
      stall_r  <= stall_nxt;
      wb_r     <= wb_nxt;
      wbq_r    <= wbq_nxt;
    end
  end

  assign stall_out   = stall_r;
  assign wb_out      = wb_r;
  assign upper_half  = upper_r;
  assign bottom_half = lower_r;

endmodule

// ===== hdl/mdu_pkg.sv
// Purpose: Shared constants and carriers for the multiply/divide unit
// Assumes: 32-bit operands, one pipeline clock
// Notes:   Opcode encoding is local to this block
package mdu_pkg;

  localparam int unsigned MDU_DATA_W  = 32;
  localparam int unsigned MDU_HALF_W  = 16;
  localparam int unsigned MDU_CNT_W   = 6;

  // Divide iteration counts: full width and skips per narrow dividend
  localparam logic [5:0] MDU_DIV_ITER   = 6'h20;
  localparam logic [5:0] MDU_SKIP_8     = 6'h17;
  localparam logic [5:0] MDU_SKIP_16    = 6'h0F;
  localparam logic [5:0] MDU_SKIP_24    = 6'h07;

  // Reset values of the result pair
  localparam logic [31:0] MDU_UPPER_RST = 32'h0000_0000;
  localparam logic [31:0] MDU_LOWER_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    MDU_OP_NONE,
    MDU_OP_MULT,
    MDU_OP_MULT_U,
    MDU_OP_MACC,
    MDU_OP_MACC_U,
    MDU_OP_MDED,
    MDU_OP_MDED_U,
    MDU_OP_MUL,
    MDU_OP_DIV,
    MDU_OP_DIV_U,
    MDU_OP_MFUP,
    MDU_OP_MFBOT
  } mdu_op_t;

  typedef struct packed {
    mdu_op_t     op;
    logic [4:0]  dest;
    logic [31:0] operand_a;
    logic [31:0] operand_b;
  } mdu_req_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } mdu_wb_t;

endpackage
